// ---- logic/instruction_field_decoder_pkg.sv ----
package instruction_field_decoder_pkg;

  // ----------------------------------------------------------------
  // Word and field layout
  // ----------------------------------------------------------------
  localparam int unsigned insn_width = 14;
  localparam int unsigned data_width = 8;
  localparam int unsigned dest_bit = 7;
  localparam int unsigned file_lsb = 0;
  localparam int unsigned file_width = 7;
  localparam int unsigned bit_idx_lsb = 7;
  localparam int unsigned bit_idx_width = 3;
  localparam int unsigned lit8_width = 8;
  localparam int unsigned lit11_width = 11;
  localparam int unsigned lit7_width = 7;
  localparam int unsigned lit5_width = 5;
  localparam int unsigned lit9_width = 9;
  localparam int unsigned lit6_width = 6;
  localparam int unsigned ptr_sel_bit = 6;
  // Every literal field starts at bit 0
  localparam int unsigned lit_lsb = 0;
  // Lowest opcode bit of each instruction class
  localparam int unsigned class_lsb = 12;
  localparam int unsigned call_jump_lsb = 11;
  localparam int unsigned branch_lsb = 9;
  localparam int unsigned dec_op_lsb = 8;
  localparam int unsigned page_latch_lsb = 7;
  localparam int unsigned pointer_op_lsb = 7;
  localparam int unsigned bank_lsb = 5;

  // ----------------------------------------------------------------
  // Opcode patterns (upper bits above the operand field)
  // ----------------------------------------------------------------
  localparam logic [5:0] op_decrement_skip_if_zero = 6'h0b;
  localparam logic [7:0] op_dec_result_one = 8'h01;
  localparam logic [7:0] data_zero = 8'h00;
  localparam logic [1:0] class_byte = 2'h0;
  localparam logic [1:0] class_bit = 2'h1;
  localparam logic [1:0] class_literal = 2'h3;
  localparam logic [2:0] op_call_jump = 3'h2;
  localparam logic [6:0] op_load_page_latch_literal = 7'h63;
  localparam logic [8:0] op_load_bank_literal = 9'h001;
  localparam logic [4:0] op_relative_branch = 5'h19;
  localparam logic [6:0] op_offset_pointer = 7'h3e;

  // Execution sequencer states, Gray coded
  typedef enum logic [1:0] {
    st_run = 2'b00,
    st_skip = 2'b01
  } seq_state_type;

  // Destination of a result
  typedef enum logic {
    dest_accumulator = 1'b0,
    dest_file = 1'b1
  } dest_type;

endpackage : instruction_field_decoder_pkg

// ---- logic/instruction_field_decoder.sv ----
`timescale 1ns/1ps

// Overview of operation
// [RL1] Destination bit 0 selects accumulator, 1 selects the addressed file register.
// [RL2] Byte and bit instructions take the file address from bits 6 to 0.
// [RL3] Bit instructions take a 3-bit bit index from bits 9 to 7.
// [RL4] Literal and control instructions supply an 8-bit literal from bits 7 to 0.
// [RL5] Call and absolute jump supply an 11-bit target from bits 10 to 0.
// [RL6] Load page latch literal supplies a 7-bit value from bits 6 to 0.
// [RL7] Load bank literal supplies a 5-bit value from bits 4 to 0.
// [RL8] Relative branch supplies a 9-bit offset from bits 8 to 0.
// [RL9] Offset pointer instructions supply pointer select bit 6 and 6-bit offset.
// [RL10] Decrement-skip reads the register, subtracts one, leaves status flags alone.
// [RL11] Decrement-skip result goes to accumulator when d clear, register when set.
// [RL12] A zero result turns the next instruction into a no-operation cycle.
// [RL13] Instruction word is 14 bits; opcode bits above each field pick the layout.
module instruction_field_decoder #(
  parameter int unsigned insn_width = instruction_field_decoder_pkg::insn_width
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic insn_valid,
  input wire logic [insn_width-1:0] insn_word,
  input wire logic [7:0] file_rd_data,
  output logic [6:0] file_addr,
  output logic dest_select,
  output logic [2:0] bit_index,
  output logic [7:0] literal8,
  output logic [10:0] literal11,
  output logic [6:0] literal7,
  output logic [4:0] literal5,
  output logic [8:0] literal9,
  output logic [5:0] literal6,
  output logic pointer_select,
  output logic is_call_jump,
  output logic is_load_page_latch_literal,
  output logic is_load_bank_literal,
  output logic is_relative_branch,
  output logic is_offset_pointer,
  output logic is_byte_op,
  output logic is_bit_op,
  output logic is_literal_op,
  output logic dec_valid,
  output logic [7:0] dec_result,
  output logic dec_wr_accumulator,
  output logic dec_wr_file,
  output logic status_hold,
  output logic skip_active,
  output logic insn_squash
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The field layout is fixed by the opcode map, so only 14 bits work
  if (insn_width != instruction_field_decoder_pkg::insn_width) begin : g_width_check
    $error("insn_width must be 14");
  end

  // Upper opcode bits above a field; used by the byte, bit, literal, call/jump and branch class tests
  function automatic logic [5:0] top_bits(input logic [13:0] w, input int unsigned lsb);
    logic [13:0] s;
    s = w >> lsb;
    return s[5:0];
  endfunction : top_bits

  // ----------------------------------------------------------------
  // Field decode registers
  // ----------------------------------------------------------------
  logic [6:0] file_addr_q, file_addr_d;
  logic dest_q, dest_d;
  logic [2:0] bit_index_q, bit_index_d;
  logic [7:0] lit8_q, lit8_d;
  logic [10:0] lit11_q, lit11_d;
  logic [6:0] lit7_q, lit7_d;
  logic [4:0] lit5_q, lit5_d;
  logic [8:0] lit9_q, lit9_d;
  logic [5:0] lit6_q, lit6_d;
  logic ptr_q, ptr_d;
  logic [7:0] class_q, class_d;

  // Fields are sliced on every valid word and held otherwise; class strobes pick which one is live
  always_comb begin
    file_addr_d = file_addr_q;
    dest_d = dest_q;
    bit_index_d = bit_index_q;
    lit8_d = lit8_q;
    lit11_d = lit11_q;
    lit7_d = lit7_q;
    lit5_d = lit5_q;
    lit9_d = lit9_q;
    lit6_d = lit6_q;
    ptr_d = ptr_q;
    class_d = '0;
    if (insn_valid) begin
      file_addr_d = insn_word[instruction_field_decoder_pkg::file_lsb
        +: instruction_field_decoder_pkg::file_width]; // see [RL2]
      dest_d = insn_word[instruction_field_decoder_pkg::dest_bit]; // see [RL1]
      bit_index_d = insn_word[instruction_field_decoder_pkg::bit_idx_lsb
        +: instruction_field_decoder_pkg::bit_idx_width]; // see [RL3]
      lit8_d = insn_word[instruction_field_decoder_pkg::lit_lsb
        +: instruction_field_decoder_pkg::lit8_width]; // see [RL4]
      lit11_d = insn_word[instruction_field_decoder_pkg::lit_lsb
        +: instruction_field_decoder_pkg::lit11_width]; // see [RL5]
      lit7_d = insn_word[instruction_field_decoder_pkg::lit_lsb
        +: instruction_field_decoder_pkg::lit7_width]; // see [RL6]
      lit5_d = insn_word[instruction_field_decoder_pkg::lit_lsb
        +: instruction_field_decoder_pkg::lit5_width]; // see [RL7]
      lit9_d = insn_word[instruction_field_decoder_pkg::lit_lsb
        +: instruction_field_decoder_pkg::lit9_width]; // see [RL8]
      lit6_d = insn_word[instruction_field_decoder_pkg::lit_lsb
        +: instruction_field_decoder_pkg::lit6_width]; // see [RL9]
      ptr_d = insn_word[instruction_field_decoder_pkg::ptr_sel_bit]; // see [RL9]
      // Layout chosen from opcode bits above each field, see [RL13]
      class_d[0] = top_bits(insn_word, instruction_field_decoder_pkg::class_lsb)
        == {4'h0, instruction_field_decoder_pkg::class_byte};
      class_d[1] = top_bits(insn_word, instruction_field_decoder_pkg::class_lsb)
        == {4'h0, instruction_field_decoder_pkg::class_bit};
      class_d[2] = top_bits(insn_word, instruction_field_decoder_pkg::class_lsb)
        == {4'h0, instruction_field_decoder_pkg::class_literal};
      class_d[3] = top_bits(insn_word, instruction_field_decoder_pkg::call_jump_lsb)
        == {3'h0, instruction_field_decoder_pkg::op_call_jump};
      class_d[4] = insn_word[insn_width-1:instruction_field_decoder_pkg::page_latch_lsb]
        == instruction_field_decoder_pkg::op_load_page_latch_literal;
      class_d[5] = insn_word[insn_width-1:instruction_field_decoder_pkg::bank_lsb]
        == instruction_field_decoder_pkg::op_load_bank_literal;
      class_d[6] = top_bits(insn_word, instruction_field_decoder_pkg::branch_lsb)
        == {1'h0, instruction_field_decoder_pkg::op_relative_branch};
      class_d[7] = insn_word[insn_width-1:instruction_field_decoder_pkg::pointer_op_lsb]
        == instruction_field_decoder_pkg::op_offset_pointer;
    end
  end

  // Registered so the datapath sees stable fields for a whole cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      file_addr_q <= '0;
      dest_q <= 1'b0;
      bit_index_q <= '0;
      lit8_q <= '0;
      lit11_q <= '0;
      lit7_q <= '0;
      lit5_q <= '0;
      lit9_q <= '0;
      lit6_q <= '0;
      ptr_q <= 1'b0;
      class_q <= '0;
    end else begin
      file_addr_q <= file_addr_d;
      dest_q <= dest_d;
      bit_index_q <= bit_index_d;
      lit8_q <= lit8_d;
      lit11_q <= lit11_d;
      lit7_q <= lit7_d;
      lit5_q <= lit5_d;
      lit9_q <= lit9_d;
      lit6_q <= lit6_d;
      ptr_q <= ptr_d;
      class_q <= class_d;
    end
  end

  // ----------------------------------------------------------------
  // Decrement and skip sequencer
  // ----------------------------------------------------------------
  instruction_field_decoder_pkg::seq_state_type state_q, state_d;
  logic dec_live;

  // Flag only on a live decrement-skip word that is not itself squashed
  always_comb begin
    dec_live = 1'b0;
    if (insn_valid && state_q == instruction_field_decoder_pkg::st_run) begin
      dec_live = insn_word[insn_width-1:instruction_field_decoder_pkg::dec_op_lsb]
        == instruction_field_decoder_pkg::op_decrement_skip_if_zero;
    end
  end

  // A zero result turns the following fetch into a no-operation slot
  always_comb begin
    state_d = state_q;
    case (state_q)
      instruction_field_decoder_pkg::st_run: begin
        // A contents of one decrements to zero; cheaper than testing the result
        if (dec_live && file_rd_data == instruction_field_decoder_pkg::op_dec_result_one) begin
          state_d = instruction_field_decoder_pkg::st_skip; // see [RL12]
        end
      end
      instruction_field_decoder_pkg::st_skip: begin
        if (insn_valid) begin
          state_d = instruction_field_decoder_pkg::st_run;
        end
      end
      default: state_d = instruction_field_decoder_pkg::st_run;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= instruction_field_decoder_pkg::st_run;
    end else begin
      state_q <= state_d;
    end
  end

  // Decrement result is combinational: the file read arrives the same cycle
  always_comb begin
    dec_valid = dec_live;
    dec_result = file_rd_data - instruction_field_decoder_pkg::op_dec_result_one; // see [RL10]
    dec_wr_accumulator = dec_live && (insn_word[instruction_field_decoder_pkg::dest_bit]
      == instruction_field_decoder_pkg::dest_accumulator); // see [RL11]
    dec_wr_file = dec_live && (insn_word[instruction_field_decoder_pkg::dest_bit]
      == instruction_field_decoder_pkg::dest_file); // see [RL11]
    status_hold = dec_live; // see [RL10]
    insn_squash = insn_valid && state_q == instruction_field_decoder_pkg::st_skip; // see [RL12]
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign file_addr = file_addr_q;
  assign dest_select = dest_q;
  assign bit_index = bit_index_q;
  assign literal8 = lit8_q;
  assign literal11 = lit11_q;
  assign literal7 = lit7_q;
  assign literal5 = lit5_q;
  assign literal9 = lit9_q;
  assign literal6 = lit6_q;
  assign pointer_select = ptr_q;
  assign is_byte_op = class_q[0];
  assign is_bit_op = class_q[1];
  assign is_literal_op = class_q[2];
  assign is_call_jump = class_q[3];
  assign is_load_page_latch_literal = class_q[4];
  assign is_load_bank_literal = class_q[5];
  assign is_relative_branch = class_q[6];
  assign is_offset_pointer = class_q[7];
  assign skip_active = state_q == instruction_field_decoder_pkg::st_skip;

endmodule : instruction_field_decoder

// ---- tb/instruction_field_decoder_checker.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checker for the decoder
// ------------------------------------------------------------
module instruction_field_decoder_checker (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic insn_valid,
  input wire logic [13:0] insn_word,
  input wire logic [7:0] file_rd_data,
  input wire logic [7:0] literal8,
  input wire logic [7:0] dec_result,
  input wire logic [6:0] file_addr,
  input wire logic [2:0] bit_index,
  input wire logic [10:0] literal11,
  input wire logic [5:0] literal6,
  input wire logic dest_select,
  input wire logic pointer_select,
  input wire logic is_byte_op,
  input wire logic is_bit_op,
  input wire logic dec_valid,
  input wire logic dec_wr_file,
  input wire logic dec_wr_accumulator,
  input wire logic status_hold,
  input wire logic skip_active,
  input wire logic insn_squash
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // A word taken at this edge; its fields must show at the next
  sequence seq_taken;
    insn_valid;
  endsequence
  // A decrement whose result is zero
  sequence seq_zero_dec;
    dec_valid && file_rd_data == 8'h01;
  endsequence
  AST_FILE_ADDR: assert property (seq_taken |=>
    file_addr == $past(insn_word[6:0])) else $error("file address wrong");
  AST_DEST_SEL: assert property (seq_taken |=>
    dest_select == $past(insn_word[7])) else $error("destination wrong");
  AST_BIT_INDEX: assert property (seq_taken |=>
    bit_index == $past(insn_word[9:7])) else $error("bit index wrong");
  AST_LIT8: assert property (seq_taken |=>
    literal8 == $past(insn_word[7:0])) else $error("literal8 wrong");
  AST_LIT11: assert property (seq_taken |=>
    literal11 == $past(insn_word[10:0])) else $error("literal11 wrong");
  AST_PTR_OFS: assert property (seq_taken |=>
    {pointer_select, literal6} == $past(insn_word[6:0])) else $error("offset wrong");
  AST_CLASS: assert property (seq_taken |=>
    {is_byte_op, is_bit_op} == {$past(insn_word[13:12]) == 2'h0,
    $past(insn_word[13:12]) == 2'h1}) else $error("class flag wrong");
  AST_DEC_MATH: assert property (dec_valid |->
    dec_result == file_rd_data - 8'h01 && status_hold) else $error("decrement wrong");
  AST_DEC_DEST: assert property (dec_valid |->
    dec_wr_file == insn_word[7] && dec_wr_accumulator != insn_word[7])
    else $error("write target wrong");
  AST_SKIP: assert property (seq_zero_dec |=> skip_active &&
    (!insn_valid || (insn_squash && !dec_valid))) else $error("skip missing");
  AST_SQUASH_CLEAR: assert property (insn_squash |=> !skip_active)
    else $error("squashed word skipped");
endmodule : instruction_field_decoder_checker

bind instruction_field_decoder instruction_field_decoder_checker checker_inst (.*);

// ---- tb/file_reg_model.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// File register read path
// ------------------------------------------------------------
module file_reg_model (
  input wire logic [6:0] addr,
  output logic [7:0] rd_data
);
  // Each register holds its own address: address 1 gives a zero result, 0 wraps
  assign rd_data = {1'b0, addr};
endmodule : file_reg_model

// ---- tb/instruction_field_decoder_test.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// Decoder bench
// ------------------------------------------------------------
module instruction_field_decoder_test;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic insn_valid = 1'b0;
  logic [13:0] insn_word = 14'h0000;
  logic [7:0] file_rd_data, literal8, dec_result;
  logic [6:0] file_addr, literal7;
  logic [2:0] bit_index;
  logic [10:0] literal11;
  logic [4:0] literal5;
  logic [8:0] literal9;
  logic [5:0] literal6;
  logic dest_select, pointer_select, is_call_jump, is_load_page_latch_literal;
  logic is_load_bank_literal, is_relative_branch, is_offset_pointer, is_byte_op;
  logic is_bit_op, is_literal_op, dec_valid, dec_wr_accumulator, dec_wr_file;
  logic status_hold, skip_active, insn_squash;
  int error_cnt = 0;
  int n_compared = 0;
  wire [7:0] flag_vec = {is_byte_op, is_bit_op, is_literal_op, is_call_jump,
    is_load_page_latch_literal, is_load_bank_literal, is_relative_branch, is_offset_pointer};

  instruction_field_decoder instruction_field_decoder_inst (.*);
  file_reg_model file_reg_model_inst (.addr(insn_word[6:0]), .rd_data(file_rd_data));

  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Drive one word just after the edge, then let that edge's updates land
  task automatic put(input logic [13:0] w, input logic v);
    @(posedge clk_sys);
    insn_valid <= v;
    insn_word <= w;
    #1;
  endtask : put

  // Flags are pulses: on for the cycle after the word, off once the bus idles
  task automatic class_test();
    logic [13:0] ws [8] = '{14'h0b85, 14'h1380, 14'h3f00, 14'h2000,
      14'h3180, 14'h0020, 14'h3200, 14'h1f00};
    foreach (ws[i]) begin
      put(ws[i], 1'b1);
      put(ws[i], 1'b0);
      chk(flag_vec, {ws[i][13:12] == 2'h0, ws[i][13:12] == 2'h1, ws[i][13:12] == 2'h3,
        ws[i][13:11] == 3'h2, ws[i][13:7] == 7'h63, ws[i][13:5] == 9'h001,
        ws[i][13:9] == 5'h19, ws[i][13:7] == 7'h3e});
      put(ws[i], 1'b0);
      chk(flag_vec, 16'h0000);
    end
  endtask : class_test

  // All-ones and alternating words catch swapped or shifted field slices
  task automatic fields_test();
    logic [13:0] ws [3] = '{14'h3fff, 14'h2aaa, 14'h1555};
    foreach (ws[i]) begin
      put(ws[i], 1'b1);
      put(ws[i], 1'b0);
      chk(file_addr, ws[i][6:0]);
      chk(dest_select, ws[i][7]);
      chk(bit_index, ws[i][9:7]);
      chk(literal8, ws[i][7:0]);
      chk(literal11, ws[i][10:0]);
      chk(literal7, ws[i][6:0]);
      chk(literal5, ws[i][4:0]);
      chk(literal9, ws[i][8:0]);
      chk({pointer_select, literal6}, ws[i][6:0]);
    end
  endtask : fields_test

  // Back-to-back decrements: plain, wrap-around, zero skip, squash, recovery
  task automatic dec_test();
    put(14'h0b05, 1'b1);
    chk({dec_valid, dec_wr_accumulator, dec_wr_file}, 16'h0006);
    chk({status_hold, dec_result}, {8'h01, 8'h04});
    put(14'h0b80, 1'b1);
    chk({dec_wr_accumulator, dec_wr_file, insn_squash, dec_result}, 16'h02ff);
    put(14'h0b81, 1'b1);
    chk({dec_valid, dec_result}, {8'h01, 8'h00});
    put(14'h0b81, 1'b1);
    chk({skip_active, insn_squash, dec_valid}, 16'h0006);
    put(14'h0b81, 1'b1);
    chk({insn_squash, dec_valid, skip_active}, 16'h0002);
    put(14'h0b81, 1'b0);
  endtask : dec_test

  // A reset in mid-run must drop the skip left pending by the last decrement
  task automatic reset_test();
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    put(14'h0b85, 1'b1);
    chk({skip_active, insn_squash, dec_valid}, 16'h0001);
    // The address left by the last decrement must be gone after reset
    chk(file_addr, 16'h0000);
  endtask : reset_test

  task automatic end_sim();
    $display("errors=%0d compared=%0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  // Watchdog: the tests need under a hundred cycles
  initial begin
    repeat (1000) @(posedge clk_sys);
    error_cnt++;
    end_sim();
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    class_test();
    fields_test();
    dec_test();
    reset_test();
    end_sim();
  end
endmodule : instruction_field_decoder_test
